// ---- src/mmd_map.svh ----
// address map, option bit positions and reset values of the memory map decoder
`ifndef MMD_MAP_SVH
`define MMD_MAP_SVH
`define MMD_OPT_FIRST 16'h003c
`define MMD_OPT_LAST 16'h003f
`define MMD_VEC_LAST 16'h00ff
`define MMD_RESET_VEC 16'h0100
`define MMD_BOOT_BASE 16'h0100
`define MMD_VEC_0 16'h0200
`define MMD_VEC_1 16'h0300
`define MMD_VEC_2 16'h0500
`define MMD_VEC_3 16'h0900
`define MMD_OPT_ERASED 8'hff
`define MMD_RELOC_BIT 7
`define MMD_VSEL_HI 6
`define MMD_VSEL_LO 5
`define MMD_PROT_BIT 2
`define MMD_PSIZE_HI 1
`define MMD_PSIZE_LO 0
`define MMD_WAKE_BIT 0
`define MMD_MEM_HI 7
`define MMD_MEM_LO 6
`define MMD_MEM_2K 2'b01
`define MMD_SET1_BASE 8'hc0
`define MMD_SYS_BASE 8'hd0
`define MMD_BANK_BASE 8'he0
`define MMD_WP_LOW_ADDR 8'hd6
`define MMD_WP_HIGH_ADDR 8'hd7
`define MMD_PAGE_ADDR 8'hdf
`define MMD_WP_LOW_RST 8'hc0
`define MMD_WP_HIGH_RST 8'hc8
`define MMD_PAGE_RST 8'h00
`define MMD_SET2_INDEX 9'h0d0
`define MMD_GP_DEPTH 272
`endif

// ---- src/mmd_pkg.sv ----
// types shared by the memory map decoder
package mmd_pkg;
  typedef enum logic [1:0] {
    MMD_MODE_REG = 2'h0,
    MMD_MODE_WORK = 2'h1,
    MMD_MODE_IND = 2'h2,
    MMD_MODE_IDX = 2'h3
  } mmd_mode_t;
  typedef enum logic [1:0] {
    MMD_ST_LOAD = 2'b01,
    MMD_ST_RUN = 2'b10
  } mmd_state_t;
  typedef enum logic [2:0] {
    MMD_K_GP = 3'b001,
    MMD_K_CTL = 3'b010,
    MMD_K_BAD = 3'b100
  } mmd_kind_t;
  typedef struct packed {
    mmd_kind_t kind;
    logic [8:0] index;
    logic [7:0] eff;
  } mmd_dec_t;
  typedef struct packed {
    logic [15:0] reset_vec;
    logic prot_en;
    logic [15:0] prot_end;
    logic wake_reset;
    logic exec_2k;
  } mmd_cfg_t;
  typedef struct packed {
    logic vector_area;
    logic option_byte;
    logic boot_area;
    logic protected_area;
  } mmd_region_t;
endpackage

// ---- src/mmd_memory_map_decoder.sv ----
// program memory and register file address decoder with option byte capture
// Notes on behaviour
// - program space decoded by full 16-bit address
// - 8-bit register bus for address and data
// - lowest 256 bytes are vectors, else program
// - option bytes 003c-003f, only 3e/3f matter
// - erased options: vector 0100, no protection
// - fetch starts at 0100 by default
// - 3e.7 low relocates vector, else 3e.6:5 ignored
// - relocated vector 0200/0300/0500/0900, sector below
// - 3e.2 low refuses erase/program of 0100 up to the 3e.1:0 sector end
// - 3f.0 low: stop wake also resets
// - 3f.0 high: stop wake without reset
// - 3f.7:6 equal 01 selects 2 KB exec ram
// - 333 registers: 272 general, rest control
// - set 1 sits at c0-ff
// - e0-ff banked, reset selects bank 0
// - common area c0-cf only by working mode
// - set 2 aliases c0-ff, indirect/indexed only
// - page select at df resets to zero
// - prime area 00-bf open to every mode
// - pointers at d6/d7 reset to c0/c8
// - working address: pointer, slice, register
`timescale 1ns/1ps
`include "mmd_map.svh"
module mmd_memory_map_decoder import mmd_pkg::*; #(
  parameter int GP_DEPTH = `MMD_GP_DEPTH
) (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic en_i,
  input wire logic [7:0] opt_3e_i,
  input wire logic [7:0] opt_3f_i,
  input wire logic [15:0] prog_addr_i,
  input wire logic flash_op_req_i,
  input wire logic [15:0] flash_op_addr_i,
  input wire logic in_stop_i,
  input wire logic ext_int_en_i,
  input wire logic ext_int_fall_i,
  input wire logic reg_rd_i,
  input wire logic reg_wr_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire mmd_mode_t reg_mode_i,
  input wire logic bank_zero_select_op_i,
  input wire logic bank_one_select_op_i,
  input wire logic [7:0] periph_rdata_i,
  output logic cpu_hold_o,
  output logic [15:0] reset_vector_o,
  output logic exec_ram_2k_o,
  output mmd_region_t prog_region_o,
  output logic flash_op_grant_o,
  output logic flash_op_refused_o,
  output logic stop_release_o,
  output logic wake_reset_o,
  output logic [7:0] reg_rdata_o,
  output logic rf_illegal_o,
  output logic periph_sel_o,
  output logic periph_we_o,
  output logic [7:0] periph_addr_o,
  output logic periph_bank_o,
  output logic bank_o
);
  // refuse a storage depth that the set 2 and common decode cannot serve
  if (GP_DEPTH != `MMD_GP_DEPTH) begin : g_depth_check
    $error("GP_DEPTH must equal the general register count");
  end

  // relocated vector, and end of the matching boot sector
  function automatic logic [15:0] vec_of(input logic [1:0] sel);
    logic [15:0] v;
    v = `MMD_VEC_0;
    unique case (sel)
      2'h0: v = `MMD_VEC_0;
      2'h1: v = `MMD_VEC_1;
      2'h2: v = `MMD_VEC_2;
      2'h3: v = `MMD_VEC_3;
    endcase
    return v;
  endfunction

  // register address decode by addressing mode
  function automatic mmd_dec_t rf_decode(input mmd_mode_t mode, input logic [7:0] a,
                                         input logic [7:0] wlo, input logic [7:0] whi);
    mmd_dec_t d;
    logic [7:0] ptr;
    ptr = a[3] ? whi : wlo;
    d.eff = a;
    d.kind = MMD_K_GP;
    d.index = {1'b0, a};
    if (mode == MMD_MODE_WORK) begin
      d.eff = {ptr[7:3], a[2:0]};
    end
    d.index = {1'b0, d.eff};
    if (d.eff < `MMD_SET1_BASE) begin
      d.kind = MMD_K_GP;
    end else if (mode == MMD_MODE_IND || mode == MMD_MODE_IDX) begin
      d.kind = MMD_K_GP;
      d.index = 9'(`MMD_SET2_INDEX + {3'h0, d.eff[5:0]});
    end else if (d.eff < `MMD_SYS_BASE) begin
      d.kind = (mode == MMD_MODE_WORK) ? MMD_K_GP : MMD_K_BAD;
    end else begin
      d.kind = MMD_K_CTL;
    end
    return d;
  endfunction

  mmd_state_t state_reg, state_next;
  mmd_cfg_t cfg_reg, cfg_next;
  logic bank_reg, bank_next;
  logic [7:0] wp_lo_reg, wp_lo_next;
  logic [7:0] wp_hi_reg, wp_hi_next;
  logic [7:0] page_reg, page_next;
  mmd_region_t region_reg, region_next;
  logic grant_reg, grant_next;
  logic refused_reg, refused_next;
  logic release_reg, release_next;
  logic wreset_reg, wreset_next;
  logic bad_reg, bad_next;
  logic [7:0] rdata_reg, rdata_next;
  logic gp_src_reg, gp_src_next;
  logic [7:0] gp_mem [GP_DEPTH];
  logic [7:0] gp_q;
  mmd_dec_t dec;
  logic access;
  logic internal;
  logic in_boot;

  // option capture and held configuration
  always_comb begin
    state_next = state_reg;
    cfg_next = cfg_reg;
    unique case (state_reg)
      MMD_ST_LOAD: begin
        cfg_next.reset_vec = opt_3e_i[`MMD_RELOC_BIT] ? `MMD_RESET_VEC
                           : vec_of(opt_3e_i[`MMD_VSEL_HI:`MMD_VSEL_LO]);
        cfg_next.prot_en = ~opt_3e_i[`MMD_PROT_BIT];
        cfg_next.prot_end = vec_of(opt_3e_i[`MMD_PSIZE_HI:`MMD_PSIZE_LO]);
        cfg_next.wake_reset = ~opt_3f_i[`MMD_WAKE_BIT];
        cfg_next.exec_2k = (opt_3f_i[`MMD_MEM_HI:`MMD_MEM_LO] == `MMD_MEM_2K);
        state_next = MMD_ST_RUN;
      end
      MMD_ST_RUN: begin
        state_next = MMD_ST_RUN;
      end
    endcase
  end

  // register bus decode and internal register updates
  always_comb begin
    dec = rf_decode(reg_mode_i, reg_addr_i, wp_lo_reg, wp_hi_reg);
    access = reg_rd_i | reg_wr_i;
    internal = (dec.eff == `MMD_WP_LOW_ADDR) | (dec.eff == `MMD_WP_HIGH_ADDR)
             | (dec.eff == `MMD_PAGE_ADDR);
    bank_next = bank_reg;
    if (bank_zero_select_op_i) begin
      bank_next = 1'b0;
    end else if (bank_one_select_op_i) begin
      bank_next = 1'b1;
    end
    wp_lo_next = wp_lo_reg;
    wp_hi_next = wp_hi_reg;
    page_next = page_reg;
    if (reg_wr_i && dec.kind == MMD_K_CTL) begin
      if (dec.eff == `MMD_WP_LOW_ADDR) begin
        wp_lo_next = reg_wdata_i;
      end
      if (dec.eff == `MMD_WP_HIGH_ADDR) begin
        wp_hi_next = reg_wdata_i;
      end
      if (dec.eff == `MMD_PAGE_ADDR) begin
        page_next = reg_wdata_i;
      end
    end
    rdata_next = rdata_reg;
    gp_src_next = gp_src_reg;
    if (reg_rd_i) begin
      gp_src_next = (dec.kind == MMD_K_GP);
      unique case (dec.kind)
        MMD_K_GP: rdata_next = rdata_reg;
        MMD_K_BAD: rdata_next = 8'h00;
        MMD_K_CTL: begin
          if (dec.eff == `MMD_WP_LOW_ADDR) begin
            rdata_next = wp_lo_reg;
          end else if (dec.eff == `MMD_WP_HIGH_ADDR) begin
            rdata_next = wp_hi_reg;
          end else if (dec.eff == `MMD_PAGE_ADDR) begin
            rdata_next = page_reg;
          end else begin
            rdata_next = periph_rdata_i;
          end
        end
        default: rdata_next = 8'h00;
      endcase
    end
    bad_next = access && (dec.kind == MMD_K_BAD);
  end

  // control and peripheral strobes, banked above e0
  always_comb begin
    periph_sel_o = access && (dec.kind == MMD_K_CTL) && !internal;
    periph_we_o = reg_wr_i && (dec.kind == MMD_K_CTL) && !internal;
    periph_addr_o = dec.eff;
    periph_bank_o = bank_reg && (dec.eff >= `MMD_BANK_BASE);
  end

  // program address regions, flash operation guard, stop wake
  always_comb begin
    region_next.vector_area = (prog_addr_i <= `MMD_VEC_LAST);
    region_next.option_byte = (prog_addr_i >= `MMD_OPT_FIRST)
                            && (prog_addr_i <= `MMD_OPT_LAST);
    region_next.boot_area = (prog_addr_i >= `MMD_BOOT_BASE)
                          && (prog_addr_i < cfg_reg.reset_vec);
    region_next.protected_area = cfg_reg.prot_en && (prog_addr_i >= `MMD_BOOT_BASE)
                               && (prog_addr_i < cfg_reg.prot_end);
    in_boot = (flash_op_addr_i >= `MMD_BOOT_BASE) && (flash_op_addr_i < cfg_reg.prot_end);
    refused_next = flash_op_req_i && cfg_reg.prot_en && in_boot;
    grant_next = flash_op_req_i && !(cfg_reg.prot_en && in_boot);
    release_next = in_stop_i && ext_int_en_i && ext_int_fall_i;
    wreset_next = release_next && cfg_reg.wake_reset;
  end

  // state registers
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_reg <= MMD_ST_LOAD;
      cfg_reg <= '{reset_vec: `MMD_RESET_VEC, prot_en: 1'b0, prot_end: `MMD_VEC_3,
                   wake_reset: 1'b0, exec_2k: 1'b0};
      bank_reg <= 1'b0;
      wp_lo_reg <= `MMD_WP_LOW_RST;
      wp_hi_reg <= `MMD_WP_HIGH_RST;
      page_reg <= `MMD_PAGE_RST;
      region_reg <= '0;
      grant_reg <= 1'b0;
      refused_reg <= 1'b0;
      release_reg <= 1'b0;
      wreset_reg <= 1'b0;
      bad_reg <= 1'b0;
      rdata_reg <= 8'h00;
      gp_src_reg <= 1'b0;
    end else if (en_i) begin
      state_reg <= state_next;
      cfg_reg <= cfg_next;
      bank_reg <= bank_next;
      wp_lo_reg <= wp_lo_next;
      wp_hi_reg <= wp_hi_next;
      page_reg <= page_next;
      region_reg <= region_next;
      grant_reg <= grant_next;
      refused_reg <= refused_next;
      release_reg <= release_next;
      wreset_reg <= wreset_next;
      bad_reg <= bad_next;
      rdata_reg <= rdata_next;
      gp_src_reg <= gp_src_next;
    end
  end

  // general purpose storage: prime, common and set 2
  always_ff @(posedge clock_i) begin
    if (en_i && dec.kind == MMD_K_GP) begin
      if (reg_wr_i) begin
        gp_mem[dec.index] <= reg_wdata_i;
      end
      if (reg_rd_i) begin
        gp_q <= gp_mem[dec.index];
      end
    end
  end

  // outputs
  always_comb begin
    cpu_hold_o = (state_reg == MMD_ST_LOAD);
    reset_vector_o = cfg_reg.reset_vec;
    exec_ram_2k_o = cfg_reg.exec_2k;
    prog_region_o = region_reg;
    flash_op_grant_o = grant_reg;
    flash_op_refused_o = refused_reg;
    stop_release_o = release_reg;
    wake_reset_o = wreset_reg;
    reg_rdata_o = gp_src_reg ? gp_q : rdata_reg;
    rf_illegal_o = bad_reg;
    bank_o = bank_reg;
  end

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);

  chk_bank_one_sel: assert property (en_i && bank_one_select_op_i
    && !bank_zero_select_op_i |=> bank_o) else $error("bank one not selected");
  chk_bank_zero_sel: assert property (en_i && bank_zero_select_op_i |=> !bank_o)
    else $error("bank zero not selected");
  chk_vec_default: assert property (en_i && cpu_hold_o && opt_3e_i[`MMD_RELOC_BIT]
    |=> reset_vector_o == `MMD_RESET_VEC) else $error("bad default vector");
  chk_cfg_hold: assert property (!cpu_hold_o |=> $stable(cfg_reg) && !cpu_hold_o)
    else $error("options changed after capture");
  chk_boot_refuse: assert property (en_i && !cpu_hold_o && flash_op_req_i
    && cfg_reg.prot_en && flash_op_addr_i == `MMD_BOOT_BASE
    |=> flash_op_refused_o && !flash_op_grant_o) else $error("boot write not refused");
  chk_wake_reset: assert property (en_i && in_stop_i && ext_int_en_i
    && ext_int_fall_i && cfg_reg.wake_reset |=> stop_release_o && wake_reset_o)
    else $error("wake reset missing");
  chk_wake_plain: assert property (en_i && in_stop_i && ext_int_en_i
    && ext_int_fall_i && !cfg_reg.wake_reset |=> stop_release_o && !wake_reset_o)
    else $error("wake reset unexpected");
  chk_common_bad: assert property (en_i && reg_rd_i && reg_mode_i == MMD_MODE_REG
    && reg_addr_i >= `MMD_SET1_BASE && reg_addr_i < `MMD_SYS_BASE |=> rf_illegal_o)
    else $error("common area not refused");
  chk_set2_route: assert property (reg_mode_i == MMD_MODE_IND
    && reg_addr_i >= `MMD_SYS_BASE |-> !periph_sel_o)
    else $error("set 2 reached control space");
  chk_opt_region: assert property (en_i && prog_addr_i == `MMD_OPT_LAST
    |=> prog_region_o.option_byte && prog_region_o.vector_area)
    else $error("option byte region missed");

  cov_capture: cover property ($fell(cpu_hold_o));
  cov_refuse: cover property (flash_op_refused_o);
  cov_wake_reset: cover property (wake_reset_o);
  cov_bank_one_periph: cover property (periph_sel_o && periph_bank_o);
endmodule

// ---- test/mmd_cpu_model.sv ----
// cpu core model: register bus master and peripheral register stub
`timescale 1ns/1ps
module mmd_cpu_model import mmd_pkg::*; (
  input wire logic clock_i,
  input wire logic periph_sel_i,
  input wire logic [7:0] periph_addr_i,
  input wire logic periph_bank_i,
  input wire logic [7:0] reg_rdata_i,
  output logic reg_rd_o,
  output logic reg_wr_o,
  output logic [7:0] reg_addr_o,
  output logic [7:0] reg_wdata_o,
  output mmd_mode_t reg_mode_o,
  output logic [7:0] periph_rdata_o
);
  logic [7:0] spin = 8'h00;
  initial begin
    reg_rd_o = 1'b0;
    reg_wr_o = 1'b0;
    reg_addr_o = 8'h00;
    reg_wdata_o = 8'h00;
    reg_mode_o = MMD_MODE_REG;
  end
  // unselected read lines change every cycle so stale data never matches
  always @(posedge clock_i) spin <= spin + 8'h3b;
  // stub answers from address and bank when selected
  assign periph_rdata_o = periph_sel_i ? periph_addr_i ^ {7'h00, periph_bank_i} ^ 8'h5a : spin;
  // one byte per access, one strobe cycle; page select only when asked
  task automatic access(input logic w, input mmd_mode_t m, input logic [7:0] a,
                        input logic [7:0] d, output logic [7:0] q, output logic s);
    @(posedge clock_i);
    reg_rd_o <= ~w;
    reg_wr_o <= w;
    reg_mode_o <= m;
    reg_addr_o <= a;
    reg_wdata_o <= d;
    #1 s = periph_sel_i;
    @(posedge clock_i);
    reg_rd_o <= 1'b0;
    reg_wr_o <= 1'b0;
    #1 q = reg_rdata_i;
  endtask
endmodule

// ---- test/tb.sv ----
// self-checking testbench of the memory map decoder
`timescale 1ns/1ps
`include "mmd_map.svh"
module tb import mmd_pkg::*; ;
  logic clock_i = 0, rst_n_i = 0, en_i = 1, s;
  logic [7:0] opt_3e_i = 8'hff, opt_3f_i = 8'hff, q, rnd = 8'h5f;
  logic [15:0] prog_addr_i = 16'h0000, flash_op_addr_i = 16'h0000;
  logic flash_op_req_i = 0, in_stop_i = 0, ext_int_en_i = 1, ext_int_fall_i = 0;
  logic bank_zero_select_op_i = 0, bank_one_select_op_i = 0;
  logic reg_rd_i, reg_wr_i, cpu_hold_o, exec_ram_2k_o, flash_op_grant_o, flash_op_refused_o;
  logic stop_release_o, wake_reset_o, rf_illegal_o, periph_sel_o, periph_we_o;
  logic periph_bank_o, bank_o;
  logic [7:0] reg_addr_i, reg_wdata_i, periph_rdata_i, reg_rdata_o, periph_addr_o;
  logic [15:0] reset_vector_o;
  mmd_mode_t reg_mode_i;
  mmd_region_t prog_region_o;
  logic [15:0] vecs [4] = '{16'h0200, 16'h0300, 16'h0500, 16'h0900};
  logic [7:0] mem [128];
  logic [127:0] vld = '0;
  int errors = 0, cmp_count = 0;
  logic [15:0] we_count = 16'h0000;
  mmd_memory_map_decoder u_dut (.clock_i, .rst_n_i, .en_i, .opt_3e_i, .opt_3f_i, .prog_addr_i,
    .flash_op_req_i, .flash_op_addr_i, .in_stop_i, .ext_int_en_i, .ext_int_fall_i, .reg_rd_i,
    .reg_wr_i, .reg_addr_i, .reg_wdata_i, .reg_mode_i, .bank_zero_select_op_i,
    .bank_one_select_op_i, .periph_rdata_i, .cpu_hold_o, .reset_vector_o, .exec_ram_2k_o,
    .prog_region_o, .flash_op_grant_o, .flash_op_refused_o, .stop_release_o, .wake_reset_o,
    .reg_rdata_o, .rf_illegal_o, .periph_sel_o, .periph_we_o, .periph_addr_o, .periph_bank_o,
    .bank_o);
  mmd_cpu_model u_cpu (.clock_i(clock_i), .periph_sel_i(periph_sel_o),
    .periph_addr_i(periph_addr_o), .periph_bank_i(periph_bank_o), .reg_rdata_i(reg_rdata_o),
    .reg_rd_o(reg_rd_i), .reg_wr_o(reg_wr_i), .reg_addr_o(reg_addr_i),
    .reg_wdata_o(reg_wdata_i), .reg_mode_o(reg_mode_i), .periph_rdata_o(periph_rdata_i));
  always #5 clock_i = ~clock_i;
  // counts peripheral write strobes seen at the taking edge
  always @(posedge clock_i) begin
    if (periph_we_o) begin
      we_count <= we_count + 16'h0001;
    end
  end
  function automatic logic [7:0] lfsr(input logic [7:0] x);
    return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
  endfunction
  task automatic final_report();
    $display("errors %0d compares %0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic check16(input string n, input logic [15:0] e, input logic [15:0] g);
    cmp_count++;
    if (g !== e) begin
      errors++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic checkb(input string n, input logic e, input logic g);
    check16(n, {15'h0000, e}, {15'h0000, g});
  endtask
  // reset with given option bytes, then bounded wait for capture
  task automatic do_reset(input logic [7:0] e, input logic [7:0] f, input int n);
    int k;
    @(posedge clock_i);
    rst_n_i <= 1'b0;
    opt_3e_i <= e;
    opt_3f_i <= f;
    repeat (n) @(posedge clock_i);
    #1;
    checkb("hold", 1'b1, cpu_hold_o);
    check16("vector", `MMD_RESET_VEC, reset_vector_o);
    checkb("bank", 1'b0, bank_o);
    @(posedge clock_i);
    rst_n_i <= 1'b1;
    k = 0;
    while (cpu_hold_o !== 1'b0 && k < 8) begin
      @(posedge clock_i);
      #1;
      k++;
    end
    if (cpu_hold_o !== 1'b0) begin
      errors++;
      final_report();
    end
  endtask
  task automatic rd(input mmd_mode_t m, input logic [7:0] a, input logic [7:0] x);
    u_cpu.access(1'b0, m, a, 8'h00, q, s);
    check16("rdata", {8'h00, x}, {8'h00, q});
  endtask
  task automatic wr(input mmd_mode_t m, input logic [7:0] a, input logic [7:0] d);
    u_cpu.access(1'b1, m, a, d, q, s);
  endtask
  task automatic bank(input logic z, input logic o, input logic x);
    @(posedge clock_i);
    bank_zero_select_op_i <= z;
    bank_one_select_op_i <= o;
    @(posedge clock_i);
    bank_zero_select_op_i <= 1'b0;
    bank_one_select_op_i <= 1'b0;
    #1;
    checkb("bank", x, bank_o);
  endtask
  // region flags one cycle after the fetch address
  task automatic region(input logic [15:0] a, input logic [7:0] e);
    logic [3:0] x;
    x = {a <= `MMD_VEC_LAST, a >= `MMD_OPT_FIRST && a <= `MMD_OPT_LAST,
         ~e[7] && a >= `MMD_BOOT_BASE && a < vecs[e[6:5]],
         ~e[2] && a >= `MMD_BOOT_BASE && a < vecs[e[1:0]]};
    @(posedge clock_i);
    prog_addr_i <= a;
    @(posedge clock_i);
    #1;
    check16("region", {12'h000, x}, {12'h000, prog_region_o});
  endtask
  task automatic flash(input logic [15:0] a, input logic r);
    @(posedge clock_i);
    flash_op_req_i <= 1'b1;
    flash_op_addr_i <= a;
    @(posedge clock_i);
    flash_op_req_i <= 1'b0;
    #1;
    checkb("refused", r, flash_op_refused_o);
    checkb("grant", ~r, flash_op_grant_o);
  endtask
  // stop wake with external interrupts enabled or masked
  task automatic wake(input logic b, input logic x);
    @(posedge clock_i);
    ext_int_en_i <= x;
    in_stop_i <= 1'b1;
    ext_int_fall_i <= 1'b1;
    @(posedge clock_i);
    in_stop_i <= 1'b0;
    ext_int_fall_i <= 1'b0;
    ext_int_en_i <= 1'b1;
    #1;
    checkb("release", x, stop_release_o);
    checkb("wake_reset", x & ~b, wake_reset_o);
  endtask
  // main sequence
  initial begin
    logic [7:0] e, f, a;
    logic [15:0] pend;
    logic [15:0] k0;
    logic [15:0] al [9];
    mmd_mode_t m;
    do_reset(8'hff, 8'hff, 12);
    check16("vector", `MMD_RESET_VEC, reset_vector_o);
    rd(MMD_MODE_REG, `MMD_WP_LOW_ADDR, `MMD_WP_LOW_RST);
    rd(MMD_MODE_REG, `MMD_WP_HIGH_ADDR, `MMD_WP_HIGH_RST);
    rd(MMD_MODE_REG, `MMD_PAGE_ADDR, `MMD_PAGE_RST);
    wr(MMD_MODE_WORK, 8'h02, 8'h11);
    wr(MMD_MODE_WORK, 8'h0a, 8'h22);
    wr(MMD_MODE_IND, 8'hc2, 8'h33);
    wr(MMD_MODE_REG, 8'hc2, 8'h44);
    checkb("illegal", 1'b1, rf_illegal_o);
    rd(MMD_MODE_REG, 8'hc2, 8'h00);
    rd(MMD_MODE_WORK, 8'h02, 8'h11);
    rd(MMD_MODE_IDX, 8'hc2, 8'h33);
    wr(MMD_MODE_IND, 8'he5, 8'h66);
    checkb("periph_sel", 1'b0, s);
    rd(MMD_MODE_IDX, 8'he5, 8'h66);
    rd(MMD_MODE_WORK, 8'h0a, 8'h22);
    wr(MMD_MODE_REG, `MMD_PAGE_ADDR, 8'h3c);
    rd(MMD_MODE_REG, `MMD_PAGE_ADDR, 8'h3c);
    rd(MMD_MODE_WORK, 8'h02, 8'h11);
    wr(MMD_MODE_REG, `MMD_WP_LOW_ADDR, 8'h40);
    wr(MMD_MODE_WORK, 8'h03, 8'h55);
    rd(MMD_MODE_REG, 8'h43, 8'h55);
    rd(MMD_MODE_REG, 8'he5, 8'he5 ^ 8'h5a);
    checkb("periph_sel", 1'b1, s);
    k0 = we_count;
    wr(MMD_MODE_REG, 8'he5, 8'h77);
    wr(MMD_MODE_REG, `MMD_WP_HIGH_ADDR, `MMD_WP_HIGH_RST);
    check16("periph_we", k0 + 16'h0001, we_count);
    bank(1'b0, 1'b1, 1'b1);
    rd(MMD_MODE_REG, 8'he5, 8'he5 ^ 8'h5b);
    bank(1'b1, 1'b1, 1'b0);
    bank(1'b0, 1'b1, 1'b1);
    // clock enable low freezes the bank flop
    @(posedge clock_i);
    en_i <= 1'b0;
    bank(1'b1, 1'b0, 1'b1);
    @(posedge clock_i);
    en_i <= 1'b1;
    bank(1'b1, 1'b0, 1'b0);
    $display("test registers done");
    // random prime area traffic in every plain mode
    for (int i = 0; i < 40; i++) begin
      rnd = lfsr(rnd);
      a = {1'b0, rnd[6:0]};
      m = rnd[1:0] == 2'h1 ? MMD_MODE_REG : mmd_mode_t'(rnd[1:0]);
      if (vld[a[6:0]] && rnd[7]) rd(m, a, mem[a[6:0]]);
      else begin
        rnd = lfsr(rnd);
        wr(m, a, rnd);
        mem[a[6:0]] = rnd;
        vld[a[6:0]] = 1'b1;
      end
    end
    $display("test prime done");
    // option bytes: every vector code and memory split, random size code
    for (int i = 0; i < 8; i++) begin
      rnd = lfsr(rnd);
      e = {i[2], i[1:0], rnd[4:3], i[0], rnd[1:0]};
      f = {i[1:0], rnd[7:3], i[0]};
      do_reset(e, f, 2);
      @(posedge clock_i);
      opt_3e_i <= ~e;
      opt_3f_i <= ~f;
      pend = vecs[e[1:0]];
      al = '{16'h003b, 16'h003c, 16'h003f, 16'h0040, 16'h00ff, 16'h0100, pend - 16'h0001,
             pend, 16'hffff};
      foreach (al[j]) begin
        region(al[j], e);
        flash(al[j], ~e[2] && al[j] >= 16'h0100 && al[j] < pend);
      end
      check16("vector", e[7] ? `MMD_RESET_VEC : vecs[e[6:5]], reset_vector_o);
      checkb("exec2k", f[7:6] == `MMD_MEM_2K, exec_ram_2k_o);
      wake(f[0], 1'b1);
      wake(f[0], 1'b0);
    end
    $display("test options done");
    final_report();
  end
endmodule
